//--- aitp_params.svh
// Summary of operation
// R1 - Serve two-wire target while bus select high
// R2 - Work at 100 kHz and 400 kHz SCL
// R3 - Single and multi-byte reads and writes
// R4 - Match seven address bits, then direction bit
// R5 - Strap high: address 0x1D, bytes 0x3A/0x3B
// R6 - Strap low: address 0x53, bytes 0xA6/0xA7
// R7 - System drives select and strap pins fixed
// R8 - Keep sample output rate within bus speed
// R9 - Read phase opens with repeated start
// R10 - Each register is eight bits wide
// R11 - First written byte loads pointer, then increments
`ifndef AITP_PARAMS_SVH
`define AITP_PARAMS_SVH
`define AITP_ADDR_HIGH 7'h1D
`define AITP_ADDR_LOW 7'h53
`define AITP_REG_AW 6
`define AITP_REG_COUNT 64
`define AITP_BYTE_BITS 4'h8
`define AITP_RD_FILL 8'hFF
`define AITP_REF_CLK_HZ 20000000
`define AITP_SCL_STD_HZ 100000
`define AITP_SCL_FAST_HZ 400000
`define AITP_QTR_STD \
  ((`AITP_REF_CLK_HZ + 4 * `AITP_SCL_STD_HZ - 1) / (4 * `AITP_SCL_STD_HZ))
`define AITP_QTR_FAST \
  ((`AITP_REF_CLK_HZ + 4 * `AITP_SCL_FAST_HZ - 1) / (4 * `AITP_SCL_FAST_HZ))
`endif

//--- aitp_pkg.sv
package aitp_pkg;
  typedef enum logic [2:0] {
    TS_IDLE, TS_ADDR, TS_ADDR_ACK, TS_WR_DATA, TS_WR_ACK, TS_RD_DATA, TS_RD_ACK
  } aitp_tgt_state_t;
  typedef enum logic [1:0] {CS_IDLE, CS_START, CS_BITS, CS_STOP} aitp_ctl_state_t;
  typedef enum logic [2:0] {
    BR_ADDR_W, BR_REG, BR_WDATA, BR_ADDR_R, BR_RDATA
  } aitp_byte_role_t;
endpackage : aitp_pkg

//--- aitp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aitp_link_if;
  logic ctl_scl_out;
  logic ctl_scl_oe;
  logic ctl_sda_out;
  logic ctl_sda_oe;
  logic tgt_sda_out;
  logic tgt_sda_oe;
  logic scl;
  logic sda;
  // Open-drain wires with pull-ups: any enabled low driver wins
  assign scl = ctl_scl_oe ? ctl_scl_out : 1'b1;
  assign sda = (ctl_sda_oe ? ctl_sda_out : 1'b1) &
               (tgt_sda_oe ? tgt_sda_out : 1'b1);
  modport controller (output ctl_scl_out, ctl_scl_oe, ctl_sda_out,
                      ctl_sda_oe, input scl, sda);
  modport target (output tgt_sda_out, tgt_sda_oe, input scl, sda);
endinterface : aitp_link_if
`default_nettype wire

//--- aitp_target.sv
`timescale 1ns/1ps
`default_nettype none
`include "aitp_params.svh"
module aitp_target (
  aitp_link_if.target link,
  input wire logic link_clk_in,
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic bus_sel_n_in,
  input wire logic address_select_strap_in,
  input wire logic user_we_in,
  input wire logic [`AITP_REG_AW-1:0] user_addr_in,
  input wire logic [7:0] user_wdata_in,
  output logic [7:0] user_rdata_out,
  output logic reg_wr_out,
  output logic [`AITP_REG_AW-1:0] reg_wr_addr_out,
  output logic [7:0] reg_wr_data_out
);
  // Link domain: sampled on the link clock
  logic lrst_meta_r;
  logic lrst_n_r;
  logic [3:0] in_meta_r;
  logic [3:0] in_s_r;
  logic [3:0] in_d_r;
  logic ack_meta_r;
  logic ack_s_r;
  aitp_pkg::aitp_tgt_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sr_r, sr_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic first_r, first_nxt;
  logic nack_r, nack_nxt;
  logic oe_r, oe_nxt;
  logic req_tgl_r, req_tgl_nxt;
  logic req_we_r, req_we_nxt;
  logic [`AITP_REG_AW-1:0] req_addr_r, req_addr_nxt;
  logic [7:0] req_wdata_r, req_wdata_nxt;
  // Reference domain
  logic [2:0] req_sync_r;
  logic ack_tgl_r;
  logic [7:0] rd_data_r;
  logic [7:0] mem [`AITP_REG_COUNT]; // see R10

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lrst_meta_r <= 1'b0;
      lrst_n_r <= 1'b0;
    end else begin
      lrst_meta_r <= 1'b1;
      lrst_n_r <= lrst_meta_r;
    end
  end

  always_ff @(posedge link_clk_in or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      in_meta_r <= 4'hF;
      in_s_r <= 4'hF;
      in_d_r <= 4'hF;
      ack_meta_r <= 1'b0;
      ack_s_r <= 1'b0;
    end else begin
      in_meta_r <= {link.scl, link.sda, bus_sel_n_in, address_select_strap_in};
      in_s_r <= in_meta_r;
      in_d_r <= in_s_r;
      ack_meta_r <= ack_tgl_r;
      ack_s_r <= ack_meta_r;
    end
  end

  wire scl_s = in_s_r[3];
  wire sda_s = in_s_r[2];
  wire scl_d = in_d_r[3];
  wire sda_d = in_d_r[2];
  wire port_enabled = in_s_r[1]; // see R1
  wire strap_s = in_s_r[0];
  wire scl_rise = scl_s & ~scl_d; // see R2
  wire scl_fall = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
  // Address bytes follow as {address, direction}: 0x3A/0x3B, 0xA6/0xA7
  wire [6:0] own_addr = strap_s ? `AITP_ADDR_HIGH : `AITP_ADDR_LOW; // see R5
  wire addr_match = (sr_r[7:1] == own_addr); // see R4, R6
  wire byte_done = scl_fall && (cnt_r == `AITP_BYTE_BITS);
  // A late fetch sends filler rather than a stale byte
  wire rd_ready = (req_tgl_r == ack_s_r);
  wire [7:0] rd_byte = rd_ready ? rd_data_r : `AITP_RD_FILL;
  wire [7:0] ptr_inc = ptr_r + 8'h01;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sr_nxt = sr_r;
    ptr_nxt = ptr_r;
    first_nxt = first_r;
    nack_nxt = nack_r;
    oe_nxt = oe_r;
    req_tgl_nxt = req_tgl_r;
    req_we_nxt = req_we_r;
    req_addr_nxt = req_addr_r;
    req_wdata_nxt = req_wdata_r;
    if (!port_enabled || stop_cond) begin
      state_nxt = aitp_pkg::TS_IDLE;
      oe_nxt = 1'b0;
    end else if (start_cond) begin
      // Repeated start also lands here; the pointer is kept
      state_nxt = aitp_pkg::TS_ADDR; // see R9
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        aitp_pkg::TS_IDLE: begin
        end
        aitp_pkg::TS_ADDR, aitp_pkg::TS_WR_DATA: begin
          if (scl_rise) begin
            sr_nxt = {sr_r[6:0], sda_s}; // see R4
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_done) begin
            cnt_nxt = 4'h0;
            if (state_r == aitp_pkg::TS_ADDR) begin
              if (addr_match) begin
                oe_nxt = 1'b1;
                state_nxt = aitp_pkg::TS_ADDR_ACK;
                if (sr_r[0]) begin
                  // Fetch early so the byte is ready by the ack's end
                  req_tgl_nxt = ~req_tgl_r;
                  req_we_nxt = 1'b0;
                  req_addr_nxt = ptr_r[`AITP_REG_AW-1:0];
                end
              end else begin
                state_nxt = aitp_pkg::TS_IDLE;
              end
            end else begin
              oe_nxt = 1'b1;
              state_nxt = aitp_pkg::TS_WR_ACK;
              if (first_r) begin
                ptr_nxt = sr_r; // see R11
                first_nxt = 1'b0;
              end else begin
                req_tgl_nxt = ~req_tgl_r; // see R3
                req_we_nxt = 1'b1;
                req_addr_nxt = ptr_r[`AITP_REG_AW-1:0];
                req_wdata_nxt = sr_r;
                ptr_nxt = ptr_inc; // see R11
              end
            end
          end
        end
        aitp_pkg::TS_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (sr_r[0]) begin
              state_nxt = aitp_pkg::TS_RD_DATA;
              sr_nxt = rd_byte;
              oe_nxt = ~rd_byte[7];
            end else begin
              state_nxt = aitp_pkg::TS_WR_DATA;
              oe_nxt = 1'b0;
              first_nxt = 1'b1;
            end
          end
        end
        aitp_pkg::TS_WR_ACK: begin
          if (scl_fall) begin
            oe_nxt = 1'b0;
            state_nxt = aitp_pkg::TS_WR_DATA;
          end
        end
        aitp_pkg::TS_RD_DATA: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_done) begin
            oe_nxt = 1'b0;
            state_nxt = aitp_pkg::TS_RD_ACK;
            ptr_nxt = ptr_inc; // see R11
            req_tgl_nxt = ~req_tgl_r; // see R3
            req_we_nxt = 1'b0;
            req_addr_nxt = ptr_inc[`AITP_REG_AW-1:0];
          end else if (scl_fall) begin
            sr_nxt = {sr_r[6:0], 1'b0};
            oe_nxt = ~sr_r[6];
          end
        end
        aitp_pkg::TS_RD_ACK: begin
          if (scl_rise) begin
            nack_nxt = sda_s;
          end else if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (nack_r) begin
              state_nxt = aitp_pkg::TS_IDLE;
            end else begin
              state_nxt = aitp_pkg::TS_RD_DATA;
              sr_nxt = rd_byte;
              oe_nxt = ~rd_byte[7];
            end
          end
        end
        default: begin
          state_nxt = aitp_pkg::TS_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_in or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      state_r <= aitp_pkg::TS_IDLE;
      cnt_r <= 4'h0;
      sr_r <= 8'h00;
      ptr_r <= 8'h00;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      oe_r <= 1'b0;
      req_tgl_r <= 1'b0;
      req_we_r <= 1'b0;
      req_addr_r <= '0;
      req_wdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sr_r <= sr_nxt;
      ptr_r <= ptr_nxt;
      first_r <= first_nxt;
      nack_r <= nack_nxt;
      oe_r <= oe_nxt;
      req_tgl_r <= req_tgl_nxt;
      req_we_r <= req_we_nxt;
      req_addr_r <= req_addr_nxt;
      req_wdata_r <= req_wdata_nxt;
    end
  end

  assign link.tgt_sda_out = 1'b0;
  assign link.tgt_sda_oe = oe_r;

  // Payload is held steady from the toggle until the next request
  wire req_edge = req_sync_r[2] ^ req_sync_r[1];
  wire bus_write = req_edge & req_we_r;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_sync_r <= 3'h0;
      ack_tgl_r <= 1'b0;
      rd_data_r <= 8'h00;
      reg_wr_out <= 1'b0;
      reg_wr_addr_out <= '0;
      reg_wr_data_out <= 8'h00;
      user_rdata_out <= 8'h00;
    end else begin
      req_sync_r <= {req_sync_r[1:0], req_tgl_r};
      reg_wr_out <= bus_write;
      user_rdata_out <= mem[user_addr_in];
      if (req_edge) begin
        ack_tgl_r <= req_sync_r[1];
        rd_data_r <= mem[req_addr_r];
        reg_wr_addr_out <= req_addr_r;
        reg_wr_data_out <= req_wdata_r;
      end
    end
  end

  // Bus writes win over a user write in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (bus_write) begin
      mem[req_addr_r] <= req_wdata_r; // see R10
    end else if (user_we_in) begin
      mem[user_addr_in] <= user_wdata_in;
    end
  end
endmodule : aitp_target
`default_nettype wire

//--- aitp_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "aitp_params.svh"
module aitp_controller (
  aitp_link_if.controller link,
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic fast_mode_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_read_in,
  input wire logic [6:0] cmd_dev_addr_in,
  input wire logic [7:0] cmd_reg_in,
  input wire logic [3:0] cmd_len_in,
  input wire logic [7:0] wr_data_in,
  output logic cmd_ready_out,
  output logic wr_take_out,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic done_out,
  output logic nack_out
);
  aitp_pkg::aitp_ctl_state_t state_r;
  aitp_pkg::aitp_byte_role_t role_r;
  logic [6:0] div_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [3:0] rem_r;
  logic [7:0] sr_r;
  logic [6:0] dev_r;
  logic [7:0] reg_r;
  logic read_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic sda_meta_r;
  logic sda_s_r;

  wire [6:0] qtr = fast_mode_in ? 7'(`AITP_QTR_FAST) : 7'(`AITP_QTR_STD); // see R2
  wire tick = (div_r == 7'h00);
  wire tx = (role_r != aitp_pkg::BR_RDATA);
  wire data_bit = (bit_r < `AITP_BYTE_BITS);
  wire last_rd = (rem_r == 4'h1);
  assign cmd_ready_out = (state_r == aitp_pkg::CS_IDLE);
  assign link.ctl_scl_out = 1'b0;
  assign link.ctl_sda_out = 1'b0;
  assign link.ctl_scl_oe = scl_oe_r;
  assign link.ctl_sda_oe = sda_oe_r;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= aitp_pkg::CS_IDLE;
      role_r <= aitp_pkg::BR_ADDR_W;
      div_r <= 7'h00;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      rem_r <= 4'h0;
      sr_r <= 8'h00;
      dev_r <= 7'h00;
      reg_r <= 8'h00;
      read_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sda_meta_r <= 1'b1;
      sda_s_r <= 1'b1;
      wr_take_out <= 1'b0;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
      done_out <= 1'b0;
      nack_out <= 1'b0;
    end else begin
      sda_meta_r <= link.sda;
      sda_s_r <= sda_meta_r;
      wr_take_out <= 1'b0;
      rd_valid_out <= 1'b0;
      done_out <= 1'b0;
      div_r <= tick ? qtr - 7'h01 : div_r - 7'h01;
      if (state_r == aitp_pkg::CS_IDLE) begin
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
        if (cmd_valid_in) begin
          state_r <= aitp_pkg::CS_START;
          role_r <= aitp_pkg::BR_ADDR_W;
          q_r <= 2'h0;
          dev_r <= cmd_dev_addr_in;
          reg_r <= cmd_reg_in;
          read_r <= cmd_read_in;
          // A read of length zero is run as a one-byte read
          rem_r <= (cmd_read_in && cmd_len_in == 4'h0) ? 4'h1 : cmd_len_in;
          nack_out <= 1'b0;
        end
      end else if (tick) begin
        q_r <= q_r + 2'h1;
        unique case (state_r)
          aitp_pkg::CS_START: begin
            unique case (q_r)
              2'h0: begin
                scl_oe_r <= 1'b1;
                sda_oe_r <= 1'b0;
              end
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b1;
              2'h3: begin
                scl_oe_r <= 1'b1;
                state_r <= aitp_pkg::CS_BITS;
                bit_r <= 4'h0;
                // Address byte: {address, direction} per R5 and R6
                sr_r <= {dev_r, role_r == aitp_pkg::BR_ADDR_R}; // see R4
              end
            endcase
          end
          aitp_pkg::CS_BITS: begin
            unique case (q_r)
              2'h0: begin
                scl_oe_r <= 1'b1;
                sda_oe_r <= data_bit ? (tx & ~sr_r[7]) : (~tx & ~last_rd);
              end
              2'h1: scl_oe_r <= 1'b0;
              2'h2: begin
                if (data_bit) begin
                  sr_r <= tx ? {sr_r[6:0], 1'b0} : {sr_r[6:0], sda_s_r};
                end else if (tx) begin
                  nack_out <= sda_s_r;
                end
              end
              2'h3: begin
                scl_oe_r <= 1'b1;
                bit_r <= data_bit ? bit_r + 4'h1 : 4'h0;
                if (!data_bit) begin
                  if (tx && nack_out) begin
                    state_r <= aitp_pkg::CS_STOP;
                  end else begin
                    unique case (role_r)
                      aitp_pkg::BR_ADDR_W: begin
                        role_r <= aitp_pkg::BR_REG;
                        sr_r <= reg_r; // see R11
                      end
                      aitp_pkg::BR_REG, aitp_pkg::BR_WDATA: begin
                        if (read_r) begin
                          role_r <= aitp_pkg::BR_ADDR_R;
                          state_r <= aitp_pkg::CS_START; // see R9
                        end else if (rem_r == 4'h0) begin
                          state_r <= aitp_pkg::CS_STOP;
                        end else begin
                          role_r <= aitp_pkg::BR_WDATA; // see R3
                          sr_r <= wr_data_in;
                          wr_take_out <= 1'b1;
                          rem_r <= rem_r - 4'h1;
                        end
                      end
                      aitp_pkg::BR_ADDR_R: role_r <= aitp_pkg::BR_RDATA;
                      aitp_pkg::BR_RDATA: begin
                        rd_data_out <= sr_r; // see R3
                        rd_valid_out <= 1'b1;
                        rem_r <= rem_r - 4'h1;
                        if (last_rd) begin
                          state_r <= aitp_pkg::CS_STOP;
                        end
                      end
                      default: state_r <= aitp_pkg::CS_STOP;
                    endcase
                  end
                end
              end
            endcase
          end
          aitp_pkg::CS_STOP: begin
            unique case (q_r)
              2'h0: begin
                scl_oe_r <= 1'b1;
                sda_oe_r <= 1'b1;
              end
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b0;
              2'h3: begin
                state_r <= aitp_pkg::CS_IDLE;
                done_out <= 1'b1;
              end
            endcase
          end
          aitp_pkg::CS_IDLE: begin
          end
        endcase
      end
    end
  end
endmodule : aitp_controller
`default_nettype wire

//--- aitp_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module aitp_link_properties (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic tgt_sda_oe_in,
  input wire logic scl_in,
  input wire logic sda_in
);
  logic [7:0] hi_cnt_r;
  logic [7:0] hi_cnt_nxt;
  // Saturates so a long idle high never wraps into a short count
  assign hi_cnt_nxt = (!scl_in) ? 8'h00 :
    (hi_cnt_r == 8'hFF) ? hi_cnt_r : hi_cnt_r + 8'h01;
  // Starts full: the bus idles high, so no short count follows reset
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hi_cnt_r <= 8'hFF;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence start_seq;
    scl_in && $fell(sda_in);
  endsequence
  sequence stop_seq;
    scl_in && $rose(sda_in);
  endsequence
  sequence tgt_hold_seq;
    ##[1:120] $rose(scl_in) ##1 scl_in [*8];
  endsequence
  AST_SCL_HIGH_MIN: assert property (
    $fell(scl_in) |-> hi_cnt_r >= 8'h0C)
    else $error("SCL high time too short");
  AST_SCL_LOW_MIN: assert property (
    $fell(scl_in) |-> !scl_in [*8])
    else $error("SCL low time too short");
  AST_START_HOLD: assert property (
    start_seq |-> scl_in [*8])
    else $error("start condition hold too short");
  AST_STOP_FREE: assert property (
    stop_seq |-> (scl_in && sda_in) [*8])
    else $error("bus not free after stop");
  AST_TGT_NO_START: assert property (
    start_seq |-> !tgt_sda_oe_in)
    else $error("target drives SDA at a start");
  AST_TGT_EDGE_LOW: assert property (
    $changed(tgt_sda_oe_in) |-> !scl_in)
    else $error("target changed SDA while SCL high");
  AST_TGT_HOLD: assert property (
    $rose(tgt_sda_oe_in) |-> tgt_sda_oe_in throughout tgt_hold_seq)
    else $error("target released SDA before SCL high ended");
  AST_SDA_QUIET_HIGH: assert property (
    scl_in && $past(scl_in) && $changed(sda_in) |-> !$past(tgt_sda_oe_in))
    else $error("target moved SDA during SCL high");
endmodule : aitp_link_properties
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic fast;
    logic strap;
    logic rd;
    logic [6:0] dev;
    logic [7:0] rg;
    logic [3:0] len;
    logic nack;
  } aitp_row_t;
  aitp_row_t rows [9] = '{
    '{1'b1, 1'b1, 1'b0, 7'h1D, 8'h10, 4'h3, 1'b0},
    '{1'b1, 1'b1, 1'b1, 7'h1D, 8'h10, 4'h3, 1'b0},
    '{1'b0, 1'b1, 1'b1, 7'h1D, 8'h11, 4'h1, 1'b0},
    '{1'b1, 1'b0, 1'b0, 7'h53, 8'h3E, 4'h3, 1'b0},
    '{1'b1, 1'b0, 1'b1, 7'h53, 8'h3E, 4'h3, 1'b0},
    '{1'b1, 1'b0, 1'b0, 7'h1D, 8'h20, 4'h1, 1'b1},
    '{1'b0, 1'b1, 1'b1, 7'h53, 8'h10, 4'h1, 1'b1},
    '{1'b0, 1'b1, 1'b0, 7'h1D, 8'h20, 4'h2, 1'b0},
    '{1'b1, 1'b1, 1'b1, 7'h1D, 8'h20, 4'h0, 1'b0}
  };
  logic ref_clk_in = 1'b0;
  logic link_clk = 1'b1;
  logic rst_n_in = 1'b0;
  logic bus_sel_n = 1'b1;
  logic strap = 1'b1;
  logic user_we = 1'b0;
  logic [5:0] user_addr = 6'h00;
  logic [7:0] user_wdata = 8'h00;
  logic fast = 1'b1;
  logic c_valid = 1'b0;
  logic c_rd = 1'b0;
  logic [6:0] c_dev = 7'h00;
  logic [7:0] c_reg = 8'h00;
  logic [3:0] c_len = 4'h0;
  logic [7:0] wr_ptr = 8'h00;
  logic take_d = 1'b0;
  logic [7:0] wr_data;
  logic [7:0] user_rdata, rd_data, wr_byte;
  logic [5:0] wr_addr;
  logic reg_wr, c_ready, wr_take, rd_valid, done, nack;
  logic [7:0] rd_q [$];
  logic [13:0] wr_q [$];
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  always #16 link_clk = ~link_clk;
  aitp_link_if aitp_link_if_i ();
  aitp_target aitp_target_i (
    .link(aitp_link_if_i.target), .link_clk_in(link_clk),
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .bus_sel_n_in(bus_sel_n), .address_select_strap_in(strap),
    .user_we_in(user_we), .user_addr_in(user_addr),
    .user_wdata_in(user_wdata), .user_rdata_out(user_rdata),
    .reg_wr_out(reg_wr), .reg_wr_addr_out(wr_addr),
    .reg_wr_data_out(wr_byte));
  aitp_controller aitp_controller_i (
    .link(aitp_link_if_i.controller), .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .fast_mode_in(fast), .cmd_valid_in(c_valid),
    .cmd_read_in(c_rd), .cmd_dev_addr_in(c_dev), .cmd_reg_in(c_reg),
    .cmd_len_in(c_len), .wr_data_in(wr_data), .cmd_ready_out(c_ready),
    .wr_take_out(wr_take), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .done_out(done), .nack_out(nack));
  aitp_link_properties aitp_link_properties_i (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .tgt_sda_oe_in(aitp_link_if_i.tgt_sda_oe),
    .scl_in(aitp_link_if_i.scl), .sda_in(aitp_link_if_i.sda));
  function automatic logic [7:0] pat(input logic [5:0] idx);
    return {2'h2, idx} ^ 8'h5C;
  endfunction : pat
  // Data held over the whole take pulse, so either sampling edge sees it
  assign wr_data = pat(wr_ptr[5:0]);
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [13:0] exp,
                     input logic [13:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  always @(negedge ref_clk_in) begin
    cycles++;
    if (rd_valid === 1'b1)
      rd_q.push_back(rd_data);
    if (reg_wr === 1'b1)
      wr_q.push_back({wr_addr, wr_byte});
    if (wr_take === 1'b1) begin
      take_d = 1'b1;
    end else if (take_d) begin
      take_d = 1'b0;
      wr_ptr = wr_ptr + 8'h01;
    end
    if (cycles == 90000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic xfer(input aitp_row_t r);
    int n;
    int t;
    logic [7:0] a;
    rd_q.delete();
    wr_q.delete();
    strap = r.strap;
    repeat (10) @(negedge ref_clk_in);
    // Bus speed sets the host's polling ceiling
    fast = r.fast;
    c_rd = r.rd;
    c_dev = r.dev;
    c_reg = r.rg;
    c_len = r.len;
    wr_ptr = r.rg;
    c_valid = 1'b1;
    @(negedge ref_clk_in);
    c_valid = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 40000) begin
      @(negedge ref_clk_in);
      t++;
    end
    chk("done", 14'h0001, {13'h0000, done});
    repeat (4) @(negedge ref_clk_in);
    chk("nack", {13'h0000, r.nack}, {13'h0000, nack});
    n = r.nack ? 0 : ((r.rd && r.len == 4'h0) ? 1 : int'(r.len));
    chk("count", 14'(n), 14'(r.rd ? rd_q.size() : wr_q.size()));
    for (int k = 0; k < n; k++) begin
      a = r.rg + 8'(k);
      if (r.rd)
        chk("rdata", {6'h00, pat(a[5:0])}, {6'h00, rd_q[k]});
      else
        chk("wdata", {a[5:0], pat(a[5:0])}, wr_q[k]);
    end
  endtask : xfer
  task automatic uwrite(input logic [5:0] ad);
    user_addr = ad;
    user_wdata = pat(ad);
    user_we = 1'b1;
    @(negedge ref_clk_in);
    user_we = 1'b0;
  endtask : uwrite
  initial begin
    repeat (5) @(negedge ref_clk_in);
    chk("ready", 14'h0001, {13'h0000, c_ready});
    chk("tgt oe", 14'h0000, {13'h0000, aitp_link_if_i.tgt_sda_oe});
    chk("reg wr", 14'h0000, {13'h0000, reg_wr});
    rst_n_in = 1'b1;
    foreach (rows[i])
      xfer(rows[i]);
    uwrite(6'h05);
    uwrite(6'h06);
    user_addr = 6'h10;
    @(negedge ref_clk_in);
    chk("user rd", {6'h00, pat(6'h10)}, {6'h00, user_rdata});
    // Pointer-only write, then a read of bytes the user side wrote
    xfer(aitp_row_t'{1'b1, 1'b1, 1'b0, 7'h1D, 8'h05, 4'h0, 1'b0});
    xfer(aitp_row_t'{1'b1, 1'b1, 1'b1, 7'h1D, 8'h05, 4'h2, 1'b0});
    bus_sel_n = 1'b0;
    xfer(aitp_row_t'{1'b1, 1'b1, 1'b0, 7'h1D, 8'h30, 4'h1, 1'b1});
    bus_sel_n = 1'b1;
    // Reset inside an address byte: both ends must let go of the bus
    fast = 1'b1;
    c_rd = 1'b0;
    c_dev = 7'h1D;
    c_reg = 8'h18;
    c_len = 4'h2;
    c_valid = 1'b1;
    @(negedge ref_clk_in);
    c_valid = 1'b0;
    repeat (300) @(negedge ref_clk_in);
    rst_n_in = 1'b0;
    repeat (5) @(negedge ref_clk_in);
    chk("rst ready", 14'h0001, {13'h0000, c_ready});
    chk("rst scl", 14'h0001, {13'h0000, aitp_link_if_i.scl});
    chk("rst sda", 14'h0001, {13'h0000, aitp_link_if_i.sda});
    rst_n_in = 1'b1;
    xfer(rows[1]);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
